// >>> core/smbsl_pkg.sv
// Constants, types and fixed tables for the SMBus register slave
// Operation
// - START detected, then eight bits shifted in
// - Seven address bits MSB first, then direction
// - Matched address acknowledged low across ninth pulse
// - Nine-pulse units, data stable while clock high
// - First written byte is the command byte
// - Master no-acknowledge ends read, device releases data
// - Line held low too long returns to idle
// - External reset also resets serial machine, via link-side synchroniser
// - Any START restarts the serial machine
// - Partial written byte is never stored
// - Aborted read byte never clears its register
// - Byte registers 00h to EFh; above reserved
// - Listed transfers supported, no PEC or ARA
// - Base address does not auto-increment
// - F0h block write, F1h process call
// - F2h-F5h fixed block reads
// - F6h-F9h fixed block reads
// - FAh-FDh fixed block reads
// - Clock and data inputs filtered against spikes
// - Address 01011 plus two select-pin bits
// - Address latched on first upper-five match
// - Block write ignores count, saturates at FFh
package smbsl_pkg;

  localparam int unsigned SMBSL_SYS_CLK_NS  = 40;
  localparam int unsigned SMBSL_LINK_CLK_NS = 48;
  localparam int unsigned SMBSL_SPIKE_NS    = 50;
  localparam int unsigned SMBSL_TOUT_MS     = 25;
  localparam int unsigned SMBSL_FILT_CYC    =
    (SMBSL_SPIKE_NS + SMBSL_LINK_CLK_NS - 1) / SMBSL_LINK_CLK_NS;
  localparam int unsigned SMBSL_TOUT_CYC    =
    (SMBSL_TOUT_MS * 1000000 + SMBSL_LINK_CLK_NS - 1) / SMBSL_LINK_CLK_NS;

  localparam int unsigned SMBSL_REG_CNT  = 240;
  localparam logic [7:0]  SMBSL_REG_LAST = 8'hef;
  localparam logic [7:0]  SMBSL_ADDR_MAX = 8'hff;
  localparam logic [4:0]  SMBSL_ADDR_HI  = 5'h0b;
  localparam logic [2:0]  SMBSL_LAST_BIT = 3'h7;
  localparam logic [7:0]  SMBSL_CMD_BLKW = 8'hf0;
  localparam logic [7:0]  SMBSL_CMD_PCAL = 8'hf1;
  localparam logic [7:0]  SMBSL_CMD_FIX0 = 8'hf2;
  localparam logic [7:0]  SMBSL_CMD_FIXN = 8'hfd;

  // Select pin levels; the code doubles as the two low address bits
  localparam logic [1:0]  SMBSL_SEL_LOW  = 2'h0;
  localparam logic [1:0]  SMBSL_SEL_HIGH = 2'h1;
  localparam logic [1:0]  SMBSL_SEL_MID  = 2'h2;

  localparam logic [7:0] SMBSL_FIX_BASE [12] = '{
    8'h40, 8'h48, 8'h50, 8'h56, 8'h67, 8'h6e,
    8'h78, 8'h90, 8'hb4, 8'hc8, 8'hd0, 8'he5};
  localparam logic [7:0] SMBSL_FIX_LEN [12] = '{
    8'h08, 8'h08, 8'h06, 8'h10, 8'h04, 8'h08,
    8'h0c, 8'h20, 8'h08, 8'h08, 8'h10, 8'h09};

  typedef enum logic [2:0] {
    SMBSL_ST_IDLE, SMBSL_ST_ADDR, SMBSL_ST_RX, SMBSL_ST_ACK,
    SMBSL_ST_TX, SMBSL_ST_TXACK, SMBSL_ST_SKIP
  } smbsl_state_t;

  typedef enum logic [2:0] {
    SMBSL_M_NONE, SMBSL_M_REG, SMBSL_M_BLKW, SMBSL_M_PCAL, SMBSL_M_FIX
  } smbsl_mode_t;

  typedef enum logic [1:0] {
    SMBSL_W_CMD, SMBSL_W_CNT, SMBSL_W_BADDR, SMBSL_W_DATA
  } smbsl_wph_t;

  // Request from link side to register side
  typedef struct packed {
    logic       wr;
    logic       commit;
    logic [7:0] waddr;
    logic [7:0] data;
    logic [7:0] faddr;
  } smbsl_req_t;

  typedef struct packed {
    logic       vld;
    logic [7:0] addr;
    logic [7:0] data;
  } smbsl_wr_t;

  typedef struct packed {
    logic       vld;
    logic [7:0] addr;
  } smbsl_clr_t;

endpackage

// >>> core/smbsl_slave.sv
// SMBus register slave: pin filter, serial engine and register bank
`timescale 1ns/1ns
module smbsl_slave
  import smbsl_pkg::*;
#(
  parameter int unsigned TOUT_CYC_P = SMBSL_TOUT_CYC,
  parameter int unsigned FILT_CYC_P = SMBSL_FILT_CYC,
  parameter int unsigned REG_CNT    = SMBSL_REG_CNT
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       link_clk,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic [1:0] addr_sel,
  input  smbsl_wr_t       mon_wr,
  input  wire logic [7:0] mon_rd_addr,
  output logic [7:0]      mon_rd_data,
  output smbsl_wr_t       host_wr,
  output smbsl_clr_t      rd_clr
);

  localparam int unsigned FW = $clog2(FILT_CYC_P + 1);
  localparam int unsigned TW = $clog2(TOUT_CYC_P + 1);

  // ---------------- Link domain ----------------
  logic             lrst_m_q;
  logic             lrst_q;
  logic [1:0]       pin_m_q;
  logic [1:0]       pin_s_q;
  logic [1:0]       sel_m_q;
  logic [1:0]       sel_s_q;
  logic             filt_q [2];
  logic [FW-1:0]    fcnt_q [2];
  logic             prev_q [2];
  logic             scl_f;
  logic             sda_f;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_ev;
  logic             stop_ev;
  logic [TW-1:0]    tcnt_q;
  logic             tout_q;
  smbsl_state_t     st_q;
  smbsl_mode_t      mode_q;
  smbsl_wph_t       wph_q;
  logic [2:0]       bit_q;
  logic [7:0]       sh_q;
  logic [7:0]       rx_byte;
  logic [7:0]       tx_byte;
  logic             rd_q;
  logic             ackdrv_q;
  logic             load_q;
  logic             txdone_q;
  logic             cnt_ph_q;
  logic             sda_oe_q;
  logic             stretch_q;
  logic [7:0]       base_q;
  logic [7:0]       wptr_q;
  logic [7:0]       rptr_q;
  logic [7:0]       rnext;
  logic [7:0]       blen_q;
  logic             lat_q;
  logic [1:0]       lat_sel_q;
  logic             addr_hi_ok;
  logic             addr_hit;
  logic [3:0]       fix_idx;
  smbsl_req_t       req_q;
  logic             req_tgl_q;
  logic             rt_m_q;
  logic             rt_s_q;
  logic             pend;

  // ---------------- System domain ----------------
  logic             rq_m_q;
  logic             rq_s_q;
  logic             rq_p_q;
  logic             rsp_tgl_q;
  logic [7:0]       rsp_data_q;
  logic [7:0]       mem_q [REG_CNT];
  smbsl_wr_t        host_wr_q;
  smbsl_clr_t       rd_clr_q;
  logic [7:0]       mon_rd_q;
  logic             req_ev;

  // Link side takes the external reset pin through a two-flop synchroniser
  always_ff @(posedge link_clk) begin
    lrst_m_q <= rst;
    lrst_q   <= lrst_m_q;
  end

  always_ff @(posedge link_clk) begin
    pin_m_q <= {sda_i, scl_i};
    pin_s_q <= pin_m_q;
    sel_m_q <= addr_sel;
    sel_s_q <= sel_m_q;
    rt_m_q  <= rsp_tgl_q;
    rt_s_q  <= rt_m_q;
  end

  // Level must persist FILT_CYC_P samples before it is believed
  for (genvar g = 0; g < 2; g++) begin : g_filt
    always_ff @(posedge link_clk) begin
      if (lrst_q) begin
        fcnt_q[g] <= '0;
        filt_q[g] <= 1'b1;
        prev_q[g] <= 1'b1;
      end else begin
        prev_q[g] <= filt_q[g];
        if (pin_s_q[g] == filt_q[g]) begin
          fcnt_q[g] <= '0;
        end else if (fcnt_q[g] == FW'(FILT_CYC_P - 1)) begin
          filt_q[g] <= pin_s_q[g];
          fcnt_q[g] <= '0;
        end else begin
          fcnt_q[g] <= fcnt_q[g] + 1'b1;
        end
      end
    end
  end

  assign scl_f    = filt_q[0];
  assign sda_f    = filt_q[1];
  assign scl_rise = scl_f & ~prev_q[0];
  assign scl_fall = ~scl_f & prev_q[0];
  assign start_ev = prev_q[1] & ~sda_f & scl_f & prev_q[0];
  assign stop_ev  = ~prev_q[1] & sda_f & scl_f & prev_q[0];

  // Own stretching counts too, but it is bounded by the handshake
  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      tcnt_q <= '0;
      tout_q <= 1'b0;
    end else if (scl_f && sda_f) begin
      tcnt_q <= '0;
      tout_q <= 1'b0;
    end else if (tcnt_q == TW'(TOUT_CYC_P - 1)) begin
      tcnt_q <= '0;
      tout_q <= 1'b1;
    end else begin
      tcnt_q <= tcnt_q + 1'b1;
      tout_q <= 1'b0;
    end
  end

  assign rx_byte    = {sh_q[6:0], sda_f};
  assign addr_hi_ok = (rx_byte[7:3] == SMBSL_ADDR_HI);
  assign addr_hit   = addr_hi_ok &&
                      (rx_byte[2:1] == (lat_q ? lat_sel_q : sel_s_q));
  assign fix_idx    = 4'(rx_byte - SMBSL_CMD_FIX0);
  assign pend       = (req_tgl_q != rt_s_q);
  assign tx_byte    = cnt_ph_q ? blen_q : rsp_data_q;
  // Block reads walk forward; plain register reads stay put
  assign rnext      = (cnt_ph_q || mode_q == SMBSL_M_REG || mode_q == SMBSL_M_NONE) ?
                      rptr_q :
                      ((rptr_q == SMBSL_ADDR_MAX) ? rptr_q : rptr_q + 8'h01);

  // Held until the next reset
  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      lat_q     <= 1'b0;
      lat_sel_q <= SMBSL_SEL_LOW;
    end else if (st_q == SMBSL_ST_ADDR && scl_rise && bit_q == SMBSL_LAST_BIT &&
                 addr_hi_ok && !lat_q && !start_ev && !stop_ev && !tout_q) begin
      lat_q     <= 1'b1;
      lat_sel_q <= sel_s_q;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      st_q      <= SMBSL_ST_IDLE;
      mode_q    <= SMBSL_M_NONE;
      wph_q     <= SMBSL_W_CMD;
      bit_q     <= '0;
      sh_q      <= '0;
      rd_q      <= 1'b0;
      ackdrv_q  <= 1'b0;
      load_q    <= 1'b0;
      txdone_q  <= 1'b0;
      cnt_ph_q  <= 1'b0;
      sda_oe_q  <= 1'b0;
      base_q    <= '0;
      wptr_q    <= '0;
      rptr_q    <= '0;
      blen_q    <= '0;
      req_q     <= '0;
      req_tgl_q <= 1'b0;
    end else if (start_ev) begin
      st_q     <= SMBSL_ST_ADDR;
      bit_q    <= '0;
      sda_oe_q <= 1'b0;
      ackdrv_q <= 1'b0;
      load_q   <= 1'b0;
      txdone_q <= 1'b0;
    end else if (stop_ev || tout_q) begin
      st_q     <= SMBSL_ST_IDLE;
      sda_oe_q <= 1'b0;
      ackdrv_q <= 1'b0;
      load_q   <= 1'b0;
      txdone_q <= 1'b0;
    end else begin
      unique case (st_q)
        SMBSL_ST_IDLE, SMBSL_ST_SKIP: begin
        end
        SMBSL_ST_ADDR: begin
          if (scl_rise) begin
            sh_q  <= rx_byte;
            bit_q <= bit_q + 3'h1;
            if (bit_q == SMBSL_LAST_BIT) begin
              if (addr_hit) begin
                st_q <= SMBSL_ST_ACK;
                rd_q <= rx_byte[0];
                if (!rx_byte[0]) begin
                  wph_q <= SMBSL_W_CMD;
                end else begin
                  // Read relies on a prior command write
                  cnt_ph_q <= (mode_q == SMBSL_M_FIX || mode_q == SMBSL_M_PCAL);
                  rptr_q   <= base_q;
                  if (!pend) begin
                    req_q     <= '{wr: 1'b0, commit: 1'b0, waddr: base_q,
                                   data: 8'h00, faddr: base_q};
                    req_tgl_q <= ~req_tgl_q;
                  end
                end
              end else begin
                st_q <= SMBSL_ST_SKIP;
              end
            end
          end
        end
        SMBSL_ST_RX: begin
          if (scl_rise) begin
            sh_q  <= rx_byte;
            bit_q <= bit_q + 3'h1;
            // Only a whole byte reaches here; aborts never commit
            if (bit_q == SMBSL_LAST_BIT) begin
              st_q <= SMBSL_ST_ACK;
              unique case (wph_q)
                SMBSL_W_CMD: begin
                  if (rx_byte <= SMBSL_REG_LAST) begin
                    mode_q <= SMBSL_M_REG;
                    base_q <= rx_byte;
                    wptr_q <= rx_byte;
                    wph_q  <= SMBSL_W_DATA;
                  end else if (rx_byte == SMBSL_CMD_BLKW) begin
                    mode_q <= SMBSL_M_BLKW;
                    wph_q  <= SMBSL_W_CNT;
                  end else if (rx_byte == SMBSL_CMD_PCAL) begin
                    mode_q <= SMBSL_M_PCAL;
                    wph_q  <= SMBSL_W_CNT;
                  end else if (rx_byte <= SMBSL_CMD_FIXN) begin
                    mode_q <= SMBSL_M_FIX;
                    base_q <= SMBSL_FIX_BASE[fix_idx];
                    blen_q <= SMBSL_FIX_LEN[fix_idx];
                    wph_q  <= SMBSL_W_DATA;
                  end else begin
                    mode_q <= SMBSL_M_NONE;
                    wph_q  <= SMBSL_W_DATA;
                  end
                end
                SMBSL_W_CNT: begin
                  // Count is only kept to answer a process call read
                  if (mode_q == SMBSL_M_PCAL) begin
                    blen_q <= rx_byte;
                  end
                  wph_q <= SMBSL_W_BADDR;
                end
                SMBSL_W_BADDR: begin
                  base_q <= rx_byte;
                  wptr_q <= rx_byte;
                  wph_q  <= SMBSL_W_DATA;
                end
                SMBSL_W_DATA: begin
                  if (mode_q != SMBSL_M_FIX && mode_q != SMBSL_M_NONE) begin
                    if (wptr_q <= SMBSL_REG_LAST && !pend) begin
                      req_q     <= '{wr: 1'b1, commit: 1'b0, waddr: wptr_q,
                                     data: rx_byte, faddr: wptr_q};
                      req_tgl_q <= ~req_tgl_q;
                    end
                    if (wptr_q != SMBSL_ADDR_MAX) begin
                      wptr_q <= wptr_q + 8'h01;
                    end
                  end
                end
              endcase
            end
          end
        end
        SMBSL_ST_ACK: begin
          if (scl_fall) begin
            if (!ackdrv_q) begin
              sda_oe_q <= 1'b1;
              ackdrv_q <= 1'b1;
            end else begin
              sda_oe_q <= 1'b0;
              ackdrv_q <= 1'b0;
              bit_q    <= '0;
              st_q     <= rd_q ? SMBSL_ST_TX : SMBSL_ST_RX;
              load_q   <= rd_q;
            end
          end
        end
        SMBSL_ST_TX: begin
          if (load_q) begin
            if (!scl_f && !pend) begin
              sda_oe_q <= ~tx_byte[7];
              sh_q     <= {tx_byte[6:0], 1'b0};
              load_q   <= 1'b0;
              bit_q    <= '0;
            end
          end else if (scl_rise) begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == SMBSL_LAST_BIT) begin
              txdone_q <= 1'b1;
            end
          end else if (scl_fall) begin
            if (txdone_q) begin
              sda_oe_q <= 1'b0;
              txdone_q <= 1'b0;
              st_q     <= SMBSL_ST_TXACK;
            end else begin
              sda_oe_q <= ~sh_q[7];
              sh_q     <= {sh_q[6:0], 1'b0};
            end
          end
        end
        SMBSL_ST_TXACK: begin
          if (scl_rise) begin
            // Clear-on-read takes effect only once the byte is fully out
            if (!pend) begin
              req_q     <= '{wr: 1'b0, commit: ~cnt_ph_q, waddr: rptr_q,
                             data: 8'h00, faddr: rnext};
              req_tgl_q <= ~req_tgl_q;
            end
            cnt_ph_q <= 1'b0;
            rptr_q   <= rnext;
            if (!sda_f) begin
              st_q   <= SMBSL_ST_TX;
              load_q <= 1'b1;
            end else begin
              st_q <= SMBSL_ST_SKIP;
            end
          end
        end
        default: st_q <= SMBSL_ST_IDLE;
      endcase
    end
  end

  // Hold the clock low while the next read byte is still in flight
  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      stretch_q <= 1'b0;
    end else begin
      stretch_q <= (st_q == SMBSL_ST_TX) && load_q && pend && !scl_f && !start_ev &&
                   !stop_ev && !tout_q;
    end
  end

  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = stretch_q;
  assign sda_oe = sda_oe_q;

  // ---------------- Register side ----------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rq_m_q <= 1'b0;
      rq_s_q <= 1'b0;
      rq_p_q <= 1'b0;
    end else begin
      rq_m_q <= req_tgl_q;
      rq_s_q <= rq_m_q;
      rq_p_q <= rq_s_q;
    end
  end

  assign req_ev = rq_s_q ^ rq_p_q;

  // Request fields are stable while the toggle is outstanding
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_tgl_q  <= 1'b0;
      rsp_data_q <= '0;
      host_wr_q  <= '0;
      rd_clr_q   <= '0;
    end else begin
      host_wr_q <= '{vld: req_ev & req_q.wr, addr: req_q.waddr, data: req_q.data};
      rd_clr_q  <= '{vld: req_ev & req_q.commit, addr: req_q.waddr};
      if (req_ev) begin
        rsp_tgl_q  <= rq_s_q;
        rsp_data_q <= (req_q.faddr < 8'(REG_CNT)) ? mem_q[req_q.faddr] : 8'h00;
      end
    end
  end

  // Host write wins over a monitor update in the same cycle
  for (genvar r = 0; r < REG_CNT; r++) begin : g_reg
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        mem_q[r] <= 8'h00;
      end else if (req_ev && req_q.wr && req_q.waddr == 8'(r)) begin
        mem_q[r] <= req_q.data;
      end else if (mon_wr.vld && mon_wr.addr == 8'(r)) begin
        mem_q[r] <= mon_wr.data;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mon_rd_q <= '0;
    end else begin
      mon_rd_q <= (mon_rd_addr < 8'(REG_CNT)) ? mem_q[mon_rd_addr] : 8'h00;
    end
  end

  assign mon_rd_data = mon_rd_q;
  assign host_wr     = host_wr_q;
  assign rd_clr      = rd_clr_q;

endmodule // smbsl_slave

// >>> verification/smbsl_host_model.sv
// Behavioural SMBus host on the open-drain clock and data lines
`timescale 1ns/1ns
module smbsl_host_model #(
  parameter int HALF = 125
) (
  input  wire logic sys_clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Slave may stretch the clock; high time counts from the real rise
  task automatic release_scl();
    int w;
    w = 0;
    scl_low = 1'b0;
    while (scl !== 1'b1 && w < 4000) begin
      @(negedge sys_clk);
      w++;
    end
    tick(HALF);
  endtask

  task automatic start();
    sda_low = 1'b0;
    tick(HALF);
    release_scl();
    sda_low = 1'b1;
    tick(HALF);
    scl_low = 1'b1;
    tick(8);
  endtask

  task automatic stop();
    sda_low = 1'b1;
    tick(HALF);
    release_scl();
    sda_low = 1'b0;
    tick(HALF);
  endtask

  // Data changes only with the clock low, with some hold after the fall
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    tick(HALF);
    release_scl();
    r = sda;
    scl_low = 1'b1;
    tick(8);
  endtask

  task automatic xfer(input logic [7:0] tx, input int nb, input logic nack,
                      output logic [7:0] rx, output logic ack);
    logic a;
    rx = 8'h00;
    ack = 1'b0;
    for (int i = 7; i > 7 - nb; i--) bit_io(tx[i], rx[i]);
    if (nb == 8) begin
      bit_io(nack, a);
      ack = !a;
    end
  endtask
endmodule // smbsl_host_model

// >>> verification/smbsl_slave_monitor.sv
// Port checker for the SMBus register slave
`timescale 1ns/1ns
module smbsl_slave_monitor
  import smbsl_pkg::*;
#(
  parameter int unsigned TOUT_CYC_P = SMBSL_TOUT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input smbsl_wr_t host_wr,
  input smbsl_clr_t rd_clr
);
  // Filter and sync add a few cycles before the slave can see the low line
  int unsigned low_cnt_q;

  always_ff @(posedge link_clk) begin
    if (rst || scl_i) begin
      low_cnt_q <= 0;
    end else if (low_cnt_q < TOUT_CYC_P + 64) begin
      low_cnt_q <= low_cnt_q + 1;
    end
  end

  property p_wr_range;
    @(posedge sys_clk) disable iff (rst) host_wr.vld |-> host_wr.addr <= SMBSL_REG_LAST;
  endproperty
  a_wr_range: assert property (p_wr_range) else $error("store outside register space");

  property p_wr_pulse;
    @(posedge sys_clk) disable iff (rst) host_wr.vld |=> !host_wr.vld;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("store pulse too long");

  property p_clr_pulse;
    @(posedge sys_clk) disable iff (rst) rd_clr.vld |=> !rd_clr.vld;
  endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("clear pulse too long");

  property p_od_zero;
    @(posedge link_clk) disable iff (rst) !scl_o && !sda_o;
  endproperty
  a_od_zero: assert property (p_od_zero) else $error("open drain level not low");

  property p_stable_high;
    @(posedge link_clk) disable iff (rst) scl_i && $past(scl_i) |-> $stable(sda_oe);
  endproperty
  a_stable_high: assert property (p_stable_high) else $error("data moved in clock high");

  property p_rose_low;
    @(posedge link_clk) disable iff (rst) $rose(sda_oe) |-> !scl_i;
  endproperty
  a_rose_low: assert property (p_rose_low) else $error("data driven in clock high");

  property p_timeout;
    @(posedge link_clk) disable iff (rst) low_cnt_q >= TOUT_CYC_P + 32 |-> !sda_oe && !scl_oe;
  endproperty
  a_timeout: assert property (p_timeout) else $error("lines held after timeout");

  property p_stretch;
    @(posedge link_clk) disable iff (rst) $rose(scl_oe) |-> ##[1:200] !scl_oe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock stretch too long");

  c_store: cover property (@(posedge sys_clk) disable iff (rst) host_wr.vld);
  c_clear: cover property (@(posedge sys_clk) disable iff (rst) rd_clr.vld);
  c_stretch: cover property (@(posedge link_clk) disable iff (rst) $rose(scl_oe));
endmodule // smbsl_slave_monitor

bind smbsl_slave smbsl_slave_monitor #(.TOUT_CYC_P(TOUT_CYC_P)) u_mon (
  .sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .host_wr(host_wr),
  .rd_clr(rd_clr));

// >>> verification/tb_top.sv
// Self-checking bench for the SMBus register slave
`timescale 1ns/1ns
module tb_top
  import smbsl_pkg::*;
;
  localparam int TOUT = 2000;
  logic       sys_clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       rst;
  logic       scl_o, scl_oe, sda_o, sda_oe, h_scl_low, h_sda_low;
  wire logic  scl = !(h_scl_low || scl_oe);
  wire logic  sda = !(h_sda_low || sda_oe);
  logic [1:0] addr_sel;
  logic [7:0] mon_rd_addr, mon_rd_data;
  smbsl_wr_t  mon_wr, host_wr, wr_last;
  smbsl_clr_t rd_clr, clr_last;
  int         errors = 0;
  int         n_checks = 0;
  int         n_wr = 0;

  always #20 sys_clk = ~sys_clk;
  always #24 link_clk = ~link_clk;

  smbsl_slave #(.TOUT_CYC_P(TOUT)) uut (
    .sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel(addr_sel),
    .mon_wr(mon_wr), .mon_rd_addr(mon_rd_addr), .mon_rd_data(mon_rd_data),
    .host_wr(host_wr), .rd_clr(rd_clr));

  smbsl_host_model host (
    .sys_clk(sys_clk), .scl(scl), .sda(sda), .scl_low(h_scl_low), .sda_low(h_sda_low));

  always @(posedge sys_clk) begin
    if (host_wr.vld === 1'b1) begin
      n_wr <= n_wr + 1;
      wr_last <= host_wr;
    end
    if (rd_clr.vld === 1'b1) clr_last <= rd_clr;
  end

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s exp %b got %b", what, exp, got);
    end
  endtask

  task automatic put(input logic [7:0] b);
    logic [7:0] rx;
    logic       a;
    host.xfer(b, 8, 1'b1, rx, a);
    chk_bit("byte ack", 1'b1, a);
  endtask

  // Address 01011 with select code 01, write direction
  task automatic wr_cmd(input logic [7:0] cmd);
    host.start();
    put(8'h5a);
    put(cmd);
  endtask

  task automatic rd_bytes(input int n, output logic [7:0] d [4]);
    logic a;
    host.start();
    put(8'h5b);
    for (int i = 0; i < n; i++) host.xfer(8'hff, 8, i == n - 1, d[i], a);
    host.stop();
  endtask

  task automatic mon_write(input logic [7:0] a, input logic [7:0] d);
    mon_wr = '{1'b1, a, d};
    @(negedge sys_clk);
    mon_wr = '0;
  endtask

  task automatic mon_read(input logic [7:0] a, output logic [7:0] d);
    mon_rd_addr = a;
    repeat (2) @(negedge sys_clk);
    d = mon_rd_data;
  endtask

  task automatic t_write_read();
    logic [7:0] d [4];
    int w0;
    w0 = n_wr;
    wr_cmd(8'h10);
    put(8'ha5);
    host.stop();
    chk_byte("store count", 8'(w0 + 1), 8'(n_wr));
    chk_byte("store addr", 8'h10, wr_last.addr);
    chk_byte("store data", 8'ha5, wr_last.data);
    wr_cmd(8'h10);
    rd_bytes(2, d);
    chk_byte("read word lo", 8'ha5, d[0]);
    chk_byte("read word hi", 8'ha5, d[1]);
    chk_byte("clear addr", 8'h10, clr_last.addr);
    $display("test write_read done");
  endtask

  task automatic t_no_match();
    logic [7:0] rx;
    logic       a;
    host.start();
    host.xfer(8'ha0, 8, 1'b1, rx, a);
    chk_bit("foreign ack", 1'b0, a);
    host.stop();
    $display("test no_match done");
  endtask

  task automatic t_fixed();
    logic [7:0] d [4];
    mon_write(8'h40, 8'h3c);
    wr_cmd(8'hf2);
    rd_bytes(2, d);
    chk_byte("f2 count", 8'h08, d[0]);
    chk_byte("f2 first", 8'h3c, d[1]);
    wr_cmd(8'hf9);
    rd_bytes(1, d);
    chk_byte("f9 count", 8'h20, d[0]);
    wr_cmd(8'hfd);
    rd_bytes(1, d);
    chk_byte("fd count", 8'h09, d[0]);
    $display("test fixed done");
  endtask

  // Register 30h reads as zero, so the slave pulls data low until it gives up
  task automatic t_timeout();
    wr_cmd(8'h30);
    host.start();
    put(8'h5b);
    host.tick(200);
    chk_bit("data driven", 1'b0, sda);
    host.tick(TOUT * 48 / 40 + 300);
    chk_bit("data released", 1'b1, sda);
    host.stop();
    $display("test timeout done");
  endtask

  task automatic t_block_write();
    logic [7:0] d;
    int w0;
    w0 = n_wr;
    wr_cmd(8'hf0);
    // Count is ignored; a leading one breaks the low run before the timeout
    put(8'h82);
    put(8'hef);
    put(8'h11);
    put(8'h22);
    host.stop();
    chk_byte("block stores", 8'(w0 + 1), 8'(n_wr));
    mon_read(8'hef, d);
    chk_byte("last register", 8'h11, d);
    $display("test block_write done");
  endtask

  task automatic t_abort();
    logic [7:0] rx;
    logic [7:0] d;
    logic       a;
    int w0;
    w0 = n_wr;
    wr_cmd(8'h20);
    host.xfer(8'h5a, 4, 1'b1, rx, a);
    host.stop();
    chk_byte("abort stores", 8'(w0), 8'(n_wr));
    mon_read(8'h20, d);
    chk_byte("abort register", 8'h00, d);
    $display("test abort done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (98000) @(posedge sys_clk);
    errors++;
    $display("watchdog expired");
    print_verdict();
  end

  // Four system cycles still give the link side three reset edges
  initial begin
    rst = 1'b1;
    mon_wr = '0;
    wr_last = '0;
    clr_last = '0;
    mon_rd_addr = 8'h00;
    addr_sel = 2'h1;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    repeat (20) @(negedge sys_clk);
    t_write_read();
    t_no_match();
    t_fixed();
    t_timeout();
    t_block_write();
    t_abort();
    print_verdict();
  end
endmodule // tb_top
